// File: hdl/ebic_idle_decode.sv
// idle state count decision for one transition between external cycles
`include "ebic_map.svh"
module ebic_idle_decode (
	input  wire logic [15:0]          ctrl,
	input  wire logic                 last_valid,
	input  wire logic                 last_write,
	input  wire logic                 last_dma,
	input  wire ebic_pkg::ebic_area_t last_area,
	input  wire logic                 next_write,
	input  wire ebic_pkg::ebic_area_t next_area,
	output ebic_pkg::ebic_count_t     need
);
	// field a: 00..11 gives one to four idle states
	function automatic ebic_pkg::ebic_count_t count_a(input logic [1:0] code);
		count_a = ebic_pkg::ebic_count_t'({1'b0, code}) + `EBIC_CNT_ONE;
	endfunction

	// field b: 00 none, 01 two, 10 three, 11 four
	function automatic ebic_pkg::ebic_count_t count_b(input logic [1:0] code);
		case (code)
			`EBIC_CODE_00: count_b = `EBIC_CNT_ZERO;
			`EBIC_CODE_01: count_b = `EBIC_CNT_TWO;
			`EBIC_CODE_10: count_b = `EBIC_CNT_THREE;
			default:       count_b = `EBIC_CNT_FOUR;
		endcase
	endfunction

	function automatic ebic_pkg::ebic_count_t cnt_max(input ebic_pkg::ebic_count_t x,
		input ebic_pkg::ebic_count_t y);
		cnt_max = (x > y) ? x : y;
	endfunction

	logic [7:0]            sel_bits;
	ebic_pkg::ebic_count_t cnt_a;
	ebic_pkg::ebic_count_t cnt_ab;

	// per-area choice between the two count fields
	always_comb
	begin
		sel_bits = ctrl[`EBIC_B_SEL_HI:`EBIC_B_SEL_LO];
		cnt_a    = count_a(ctrl[`EBIC_B_CA_HI:`EBIC_B_CA_LO]);
		cnt_ab   = sel_bits[last_area] ? count_b(ctrl[`EBIC_B_CB_HI:`EBIC_B_CB_LO]) : cnt_a;
	end

	// largest count among the transitions that apply
	always_comb
	begin
		need = `EBIC_CNT_ZERO;
		if (last_valid)
		begin
			if (last_dma && last_write && ctrl[`EBIC_B_DMA_WR])
				need = cnt_max(need, cnt_a);
			if (last_write && !next_write && ctrl[`EBIC_B_WR_RD])
				need = cnt_max(need, cnt_a);
			if (!last_write && !next_write && (last_area != next_area) && ctrl[`EBIC_B_AREA_RD])
				need = cnt_max(need, cnt_ab);
			if (!last_write && next_write && ctrl[`EBIC_B_RD_WR])
				need = cnt_max(need, cnt_ab);
		end
	end
endmodule // ebic_idle_decode

// File: hdl/ebic_idle_timer.sv
// down counter that times the inserted idle states
module ebic_idle_timer (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  load,
	input  wire ebic_pkg::ebic_count_t load_val,
	output logic                       busy,
	output logic                       last
);
	ebic_pkg::ebic_count_t cnt_ff;

	// load wins, otherwise count down to zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_ff <= '0;
		else if (load)
			cnt_ff <= load_val;
		else if (cnt_ff != '0)
			cnt_ff <= cnt_ff - 3'h1;
	end

	assign busy = (cnt_ff != '0);
	assign last = (cnt_ff == 3'h1);

	// helper: length of the current busy run, for the length check
	ebic_pkg::ebic_count_t run_ff;
	ebic_pkg::ebic_count_t loaded_ff;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			run_ff <= '0;
		else if (busy)
			run_ff <= run_ff + 3'h1;
		else
			run_ff <= '0;
	end

	// helper: count taken at the last load
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			loaded_ff <= '0;
		else if (load)
			loaded_ff <= load_val;
	end

	chk_idle_run_len: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(busy) |-> run_ff == loaded_ff)
		else $error("idle run length differs from count");
endmodule // ebic_idle_timer

// File: hdl/ebic_map.svh
// register map, field positions, reset values and limits of the idle insertion block
`ifndef EBIC_MAP_SVH
`define EBIC_MAP_SVH

// word indices of the registers (byte address is four times the index)
`define EBIC_IDX_CTRL     6'h00
`define EBIC_IDX_STAT     6'h01

// bus_idle_control reset value and field positions
`define EBIC_CTRL_RST     16'hff00
`define EBIC_B_DMA_WR     15
`define EBIC_B_WR_RD      14
`define EBIC_B_AREA_RD    13
`define EBIC_B_RD_WR      12
`define EBIC_B_CB_HI      11
`define EBIC_B_CB_LO      10
`define EBIC_B_CA_HI      9
`define EBIC_B_CA_LO      8
`define EBIC_B_SEL_HI     7
`define EBIC_B_SEL_LO     0

// idle state counts
`define EBIC_CNT_ZERO     3'h0
`define EBIC_CNT_ONE      3'h1
`define EBIC_CNT_TWO      3'h2
`define EBIC_CNT_THREE    3'h3
`define EBIC_CNT_FOUR     3'h4
`define EBIC_ELAPSED_MAX  3'h4

// two-bit count field codes
`define EBIC_CODE_00      2'h0
`define EBIC_CODE_01      2'h1
`define EBIC_CODE_10      2'h2

// axi responses
`define EBIC_RESP_OKAY    2'h0
`define EBIC_RESP_DECERR  2'h3

`endif

// File: hdl/ebic_pkg.sv
// types shared by the idle insertion block
package ebic_pkg;
	typedef enum logic [1:0] {st_wait, st_insert, st_issue} ebic_state_e;
	typedef logic [2:0] ebic_count_t;
	typedef logic [2:0] ebic_area_t;
endpackage : ebic_pkg

// File: hdl/ebic_top.sv
// idle state insertion between external bus cycles, with axi4-lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`include "ebic_map.svh"

module ebic_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 req_valid,
	input  wire logic                 req_write,
	input  wire logic                 req_dma_single,
	input  wire ebic_pkg::ebic_area_t req_area,
	output logic                      req_ready,
	output logic                      cyc_start,
	output logic                      cyc_write,
	output logic                      cyc_dma_single,
	output ebic_pkg::ebic_area_t      cyc_area,
	output logic                      idle_state
);
	// register bus state
	logic                  awready_ff;
	logic                  wready_ff;
	logic                  bvalid_ff;
	logic [1:0]            bresp_ff;
	logic                  aw_have_ff;
	logic                  w_have_ff;
	logic [5:0]            aw_idx_ff;
	logic [31:0]           wdata_ff;
	logic [3:0]            wstrb_ff;
	logic                  arready_ff;
	logic                  rvalid_ff;
	logic [31:0]           rdata_ff;
	logic [1:0]            rresp_ff;
	logic [15:0]           ctrl_ff;
	logic                  do_write;
	// sequencer state
	ebic_pkg::ebic_state_e state_ff;
	logic                  req_ready_ff;
	logic                  idle_state_ff;
	logic                  cyc_start_ff;
	logic                  cyc_write_ff;
	logic                  cyc_dma_ff;
	ebic_pkg::ebic_area_t  cyc_area_ff;
	logic                  last_valid_ff;
	ebic_pkg::ebic_count_t elapsed_ff;
	ebic_pkg::ebic_count_t last_need_ff;
	ebic_pkg::ebic_count_t need_raw;
	ebic_pkg::ebic_count_t need_left;
	logic                  tmr_busy;
	logic                  tmr_last;
	logic                  tmr_load;
	logic                  accept;
	logic                  decide;

	// write address channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_ff <= 1'b0;
			aw_have_ff <= 1'b0;
			aw_idx_ff  <= '0;
		end
		else if (s_axi_awvalid && awready_ff)
		begin
			awready_ff <= 1'b0;
			aw_have_ff <= 1'b1;
			aw_idx_ff  <= s_axi_awaddr[7:2];
		end
		else if (do_write)
			aw_have_ff <= 1'b0;
		else if (!aw_have_ff && !bvalid_ff)
			awready_ff <= 1'b1;
	end

	// write data channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wready_ff <= 1'b0;
			w_have_ff <= 1'b0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end
		else if (s_axi_wvalid && wready_ff)
		begin
			wready_ff <= 1'b0;
			w_have_ff <= 1'b1;
			wdata_ff  <= s_axi_wdata;
			wstrb_ff  <= s_axi_wstrb;
		end
		else if (do_write)
			w_have_ff <= 1'b0;
		else if (!w_have_ff && !bvalid_ff)
			wready_ff <= 1'b1;
	end
	assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

	// write response and control register update
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `EBIC_RESP_OKAY;
			ctrl_ff   <= `EBIC_CTRL_RST;
		end
		else if (do_write)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= `EBIC_RESP_OKAY;
			if (aw_idx_ff == `EBIC_IDX_CTRL)
			begin
				if (wstrb_ff[0])
					ctrl_ff[7:0] <= wdata_ff[7:0];
				if (wstrb_ff[1])
					ctrl_ff[15:8] <= wdata_ff[15:8];
			end
			else if (aw_idx_ff != `EBIC_IDX_STAT)
				bresp_ff <= `EBIC_RESP_DECERR; // unmapped
		end
		else if (bvalid_ff && s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	// read channel, one read at a time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= `EBIC_RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_ff)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= `EBIC_RESP_OKAY;
			case (s_axi_araddr[7:2])
				`EBIC_IDX_CTRL: rdata_ff <= {16'h0000, ctrl_ff};
				`EBIC_IDX_STAT: rdata_ff <= {20'h00000, idle_state_ff, last_need_ff,
					2'h0, last_valid_ff, cyc_dma_ff, cyc_write_ff, cyc_area_ff};
				default:
				begin
					rdata_ff <= '0;
					rresp_ff <= `EBIC_RESP_DECERR;
				end
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
		else if (!rvalid_ff)
			arready_ff <= 1'b1;
	end

	// count decision from the previous cycle and the waiting request
	ebic_idle_decode u_decode (
		.ctrl       (ctrl_ff),
		.last_valid (last_valid_ff),
		.last_write (cyc_write_ff),
		.last_dma   (cyc_dma_ff),
		.last_area  (cyc_area_ff),
		.next_write (req_write),
		.next_area  (req_area),
		.need       (need_raw)
	);
	// idle states already spent while the bus stood still count toward the need
	assign need_left = (need_raw > elapsed_ff) ? (need_raw - elapsed_ff) : `EBIC_CNT_ZERO;
	assign decide    = (state_ff == ebic_pkg::st_wait) && req_valid;
	assign tmr_load  = decide && (need_left != `EBIC_CNT_ZERO);
	assign accept    = (state_ff == ebic_pkg::st_issue) && req_valid && req_ready_ff;
	ebic_idle_timer u_timer (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.load     (tmr_load),
		.load_val (need_left),
		.busy     (tmr_busy),
		.last     (tmr_last)
	);
	// sequencer: wait, insert idle states, then grant one cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff      <= ebic_pkg::st_wait;
			req_ready_ff  <= 1'b0;
			idle_state_ff <= 1'b0;
			last_need_ff  <= `EBIC_CNT_ZERO;
		end
		else
		begin
			case (state_ff)
				ebic_pkg::st_wait:
					if (decide)
					begin
						last_need_ff <= need_left;
						if (tmr_load)
						begin
							idle_state_ff <= 1'b1;
							state_ff      <= ebic_pkg::st_insert;
						end
						else
						begin
							req_ready_ff <= 1'b1;
							state_ff     <= ebic_pkg::st_issue;
						end
					end
				ebic_pkg::st_insert:
					if (tmr_last || !tmr_busy)
					begin
						idle_state_ff <= 1'b0;
						req_ready_ff  <= 1'b1;
						state_ff      <= ebic_pkg::st_issue;
					end
				ebic_pkg::st_issue:
					if (accept)
					begin
						req_ready_ff <= 1'b0;
						state_ff     <= ebic_pkg::st_wait;
					end
				default:
				begin
					req_ready_ff  <= 1'b0;
					idle_state_ff <= 1'b0;
					state_ff      <= ebic_pkg::st_wait;
				end
			endcase
		end
	end
	// record the issued cycle as the previous one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cyc_start_ff  <= 1'b0;
			cyc_write_ff  <= 1'b0;
			cyc_dma_ff    <= 1'b0;
			cyc_area_ff   <= '0;
			last_valid_ff <= 1'b0;
		end
		else
		begin
			cyc_start_ff <= accept;
			if (accept)
			begin
				cyc_write_ff  <= req_write;
				cyc_dma_ff    <= req_dma_single && req_write;
				cyc_area_ff   <= req_area;
				last_valid_ff <= 1'b1;
			end
		end
	end
	// bus-idle cycles since the last issued cycle, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			elapsed_ff <= `EBIC_ELAPSED_MAX;
		else if (accept)
			elapsed_ff <= `EBIC_CNT_ZERO;
		else if ((state_ff == ebic_pkg::st_wait) && !req_valid
			&& (elapsed_ff != `EBIC_ELAPSED_MAX))
			elapsed_ff <= elapsed_ff + `EBIC_CNT_ONE;
	end
	assign s_axi_awready  = awready_ff;
	assign s_axi_wready   = wready_ff;
	assign s_axi_bvalid   = bvalid_ff;
	assign s_axi_bresp    = bresp_ff;
	assign s_axi_arready  = arready_ff;
	assign s_axi_rvalid   = rvalid_ff;
	assign s_axi_rdata    = rdata_ff;
	assign s_axi_rresp    = rresp_ff;
	assign req_ready      = req_ready_ff;
	assign cyc_start      = cyc_start_ff;
	assign cyc_write      = cyc_write_ff;
	assign cyc_dma_single = cyc_dma_ff;
	assign cyc_area       = cyc_area_ff;
	assign idle_state     = idle_state_ff;

	chk_dma_wr_gap: assert property (@(posedge aclk) disable iff (!aresetn)
		(decide && last_valid_ff && cyc_dma_ff && ctrl_ff[`EBIC_B_DMA_WR])
		|-> need_raw >= ({1'b0, ctrl_ff[`EBIC_B_CA_HI:`EBIC_B_CA_LO]} + 3'h1))
		else $error("dma write gap too short");
	chk_wr_rd_gap: assert property (@(posedge aclk) disable iff (!aresetn)
		(decide && last_valid_ff && cyc_write_ff && !req_write && ctrl_ff[`EBIC_B_WR_RD]
		&& elapsed_ff == 3'h0) |=> idle_state_ff)
		else $error("write to read gap missing");
	chk_area_rd_gap: assert property (@(posedge aclk) disable iff (!aresetn)
		(decide && last_valid_ff && !cyc_write_ff && !req_write && cyc_area_ff != req_area
		&& ctrl_ff[`EBIC_B_AREA_RD] && !ctrl_ff[cyc_area_ff] && elapsed_ff == 3'h0)
		|=> idle_state_ff ##0 last_need_ff == {1'b0, ctrl_ff[`EBIC_B_CA_HI:`EBIC_B_CA_LO]} + 3'h1)
		else $error("area change read gap wrong");
	chk_rd_wr_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(decide && last_valid_ff && !cyc_write_ff && req_write && !ctrl_ff[`EBIC_B_RD_WR])
		|-> need_raw == 3'h0)
		else $error("read to write gap while disabled");
	chk_count_b_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(decide && last_valid_ff && !cyc_write_ff && req_write && ctrl_ff[cyc_area_ff]
		&& ctrl_ff[`EBIC_B_CB_HI:`EBIC_B_CB_LO] == 2'h0)
		|=> !idle_state_ff && req_ready_ff)
		else $error("field b zero still inserted idle");
	chk_count_b_top: assert property (@(posedge aclk) disable iff (!aresetn)
		(decide && last_valid_ff && !cyc_write_ff && req_write && ctrl_ff[`EBIC_B_RD_WR]
		&& ctrl_ff[cyc_area_ff] && ctrl_ff[`EBIC_B_CB_HI:`EBIC_B_CB_LO] == 2'h3)
		|-> need_raw == 3'h4)
		else $error("field b code 11 not four");
	chk_sel_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(decide && last_valid_ff && !cyc_write_ff && req_write && ctrl_ff[`EBIC_B_RD_WR]
		&& !ctrl_ff[cyc_area_ff])
		|-> need_raw == {1'b0, ctrl_ff[`EBIC_B_CA_HI:`EBIC_B_CA_LO]} + 3'h1)
		else $error("cleared select did not pick field a");
endmodule // ebic_top

// File: testbench/ebic_ext_model.sv
// model of the external memories and peripherals on the eight areas
module ebic_ext_model (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 cyc_start,
	input  wire ebic_pkg::ebic_area_t cyc_area,
	input  wire logic                 idle_state,
	output logic [15:0]               n_access_ff,
	output logic [7:0]                area_hit_ff,
	output logic                      clash_ff
);
	timeunit 1ns;
	timeprecision 100ps;
	// count cycles, mark touched areas, flag a cycle during an idle state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			n_access_ff <= 16'h0000;
			area_hit_ff <= 8'h00;
			clash_ff    <= 1'b0;
		end
		else if (cyc_start)
		begin
			n_access_ff           <= n_access_ff + 16'h0001;
			area_hit_ff[cyc_area] <= 1'b1;
			clash_ff              <= clash_ff | idle_state;
		end
	end
endmodule // ebic_ext_model

// File: testbench/ebic_top_bench.sv
// self-checking bench of the idle insertion block
`include "ebic_map.svh"
module ebic_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic                 aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic                 arvalid, arready, rvalid, rready, req_valid, req_write, req_dma;
	logic                 req_ready, cyc_start, cyc_write, cyc_dma, idle_state, clash, pend;
	logic [7:0]           awaddr, araddr, area_hit;
	logic [31:0]          wdata, rdata, exp_cyc;
	logic [3:0]           wstrb;
	logic [1:0]           bresp, rresp;
	logic [15:0]          n_access;
	ebic_pkg::ebic_area_t req_area, cyc_area;
	int                   n_mismatch, checks, n_req, cycles;

	ebic_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .req_valid(req_valid), .req_write(req_write),
		.req_dma_single(req_dma), .req_area(req_area), .req_ready(req_ready),
		.cyc_start(cyc_start), .cyc_write(cyc_write), .cyc_dma_single(cyc_dma),
		.cyc_area(cyc_area), .idle_state(idle_state));
	ebic_ext_model u_ext (.aclk(aclk), .aresetn(aresetn), .cyc_start(cyc_start),
		.cyc_area(cyc_area), .idle_state(idle_state), .n_access_ff(n_access),
		.area_hit_ff(area_hit), .clash_ff(clash));

	// free-running clock at 4 ns
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// axi write; payload held per channel until its ready
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		r = 2'h2;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever // ends when bvalid is seen; the hang guard ends it if bvalid never comes
		begin
			@(posedge aclk);
			if (aw && awready === 1'b1)
			begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1)
			begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1)
			begin
				r = bresp;
				break;
			end
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	// axi read
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		ar = 1'b1;
		r = 2'h2;
		d = 32'h0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever // ends when rvalid is seen; the hang guard ends it if rvalid never comes
		begin
			@(posedge aclk);
			if (ar && arready === 1'b1)
			begin
				ar = 1'b0;
				arvalid <= 1'b0;
			end
			if (rvalid === 1'b1)
			begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// one edge; the cycle granted before must show its pulse and attributes here
	task automatic tick();
		@(posedge aclk);
		if (pend)
		begin
			ck({26'h0, cyc_start, cyc_dma, cyc_write, cyc_area}, exp_cyc);
			pend = 1'b0;
		end
	endtask

	// request q = {write, dma, area}; n is the idle states seen before the grant
	task automatic req(input logic [4:0] q, output int n);
		int k;
		req_valid <= 1'b1;
		req_write <= q[4];
		req_dma <= q[3];
		req_area <= q[2:0];
		n = 0;
		for (k = 0; k < 20; k++)
		begin
			tick();
			if (req_ready === 1'b1)
				break;
			if (idle_state === 1'b1)
				n++;
		end
		ck(k, n + 1); // grant one cycle after the last idle state
		exp_cyc = {26'h0, 1'b1, q[3], q[4], q[2:0]};
		pend = 1'b1;
		n_req++;
	endtask

	task automatic rel();
		req_valid <= 1'b0;
		repeat (6) tick();
	endtask

	// program the control word, run two back-to-back cycles, judge the gap
	task automatic pair(input logic [15:0] c, input logic [4:0] p, input logic [4:0] q,
		input logic [31:0] exp);
		logic [1:0] r;
		int m, n;
		axw(8'h00, {16'h0, c}, 4'hf, r);
		rel();
		req(p, m);
		req(q, n);
		rel();
		ck(n, exp);
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axr(8'h00, d, r);
		ck(d, {16'h0, `EBIC_CTRL_RST});
		ck(r, `EBIC_RESP_OKAY);
		axw(8'h00, 32'h12345678, 4'h1, r);
		ck(r, `EBIC_RESP_OKAY);
		axw(8'h04, 32'hffffffff, 4'hf, r);
		ck(r, `EBIC_RESP_OKAY);
		axw(8'h08, 32'h00000000, 4'hf, r);
		ck(r, `EBIC_RESP_DECERR);
		axr(8'h08, d, r);
		ck(d, 32'h0);
		ck(r, `EBIC_RESP_DECERR);
		axr(8'h00, d, r);
		ck(d, 32'h0000ff78);
		$display("t_regs done");
	endtask

	task automatic t_count_a();
		for (int c = 0; c < 4; c++)
			pair({6'b010000, c[1:0], 8'h00}, 5'b10000, 5'b00000, c + 1);
		pair(16'h0300, 5'b10000, 5'b00000, 0);
		$display("t_count_a done");
	endtask

	task automatic t_dma();
		pair(16'h8100, 5'b11001, 5'b10001, 2);
		pair(16'h0100, 5'b11001, 5'b10001, 0);
		pair(16'h81ff, 5'b11001, 5'b10001, 2);
		$display("t_dma done");
	endtask

	task automatic t_area_read();
		pair(16'h2200, 5'b00010, 5'b00101, 3);
		pair(16'h2200, 5'b00010, 5'b00010, 0);
		pair(16'h0200, 5'b00010, 5'b00101, 0);
		pair(16'h2804, 5'b00010, 5'b00101, 3);
		$display("t_area_read done");
	endtask

	task automatic t_read_write();
		pair(16'h1000, 5'b00011, 5'b10011, 1);
		pair(16'h0000, 5'b00011, 5'b10011, 0);
		for (int c = 0; c < 4; c++)
			pair({4'b0001, c[1:0], 10'h008}, 5'b00011, 5'b10011, (c == 0) ? 0 : c + 1);
		$display("t_read_write done");
	endtask

	task automatic t_area_select();
		logic [31:0] d;
		logic [1:0]  r;
		pair(16'h1780, 5'b00111, 5'b10111, 2);
		pair(16'h1780, 5'b00011, 5'b10011, 4);
		// status: write to area 3 was last, four idle states before it
		axr(8'h04, d, r);
		ck(d, 32'h0000042b);
		ck(r, `EBIC_RESP_OKAY);
		$display("t_area_select done");
	endtask

	// reset, scenarios, closing report
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid} = 7'h00;
		{req_write, req_dma, req_area, awaddr, araddr, wdata, wstrb} = 57'h0;
		{n_mismatch, checks, n_req, cycles} = '0;
		pend = 1'b0;
		exp_cyc = 32'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_count_a();
		t_dma();
		t_area_read();
		t_read_write();
		t_area_select();
		ck(n_access, n_req);
		ck(clash, 1'b0);
		ck(area_hit, 32'h000000af); // areas 4 and 6 are never addressed
		wrap_up();
	end
endmodule // ebic_top_bench
